// file: tb/slc_keypad_op.sv
// Behavioural operator pressing keys on the front-panel keypad.
`timescale 1ns/10ps
module slc_keypad_op (
  input wire logic i_ref_clk,
  output logic o_key_vld,
  output logic [3:0] o_key
);
  // Idle keypad shows no press and an ignored code.
  initial begin
    o_key_vld = 1'b0;
    o_key = 4'hF;
  end

  // One press lasts one cycle; released code lines show the inverse.
  task automatic press(input logic [3:0] k);
    @(posedge i_ref_clk);
    o_key_vld <= 1'b1;
    o_key <= k;
    @(posedge i_ref_clk);
    o_key_vld <= 1'b0;
    o_key <= ~k;
  endtask : press

  // Opens the lockout menu with menu/clear followed by zero.
  task automatic open_menu();
    press(slc_pkg::KEY_MENU);
    press(slc_pkg::KEY_ZERO);
  endtask : open_menu

  // Types three digits, most significant first, then enter.
  task automatic type_code(input logic [11:0] c);
    press(c[11:8]);
    press(c[7:4]);
    press(c[3:0]);
    press(slc_pkg::KEY_ENTER);
  endtask : type_code
endmodule : slc_keypad_op

// file: tb/tb_slc_lockout_ctl.sv
// Self-checking testbench of the keypad lockout controller.
`timescale 1ns/10ps
module tb_slc_lockout_ctl;
  logic i_ref_clk = 1'b0;
  logic i_rstn;
  logic i_cal_jumper;
  logic [3:0] i_addr;
  logic [7:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic key_vld;
  logic [3:0] key;
  logic [7:0] o_rdata;
  logic o_lock_on;
  logic o_autocorr_on;
  logic [3:0] o_msg;
  logic [11:0] o_disp_code;
  logic [4:0] o_range;
  logic [1:0] o_trig;
  logic [7:0] o_delay;
  logic [1:0] o_comm;
  logic [0:0] o_line;
  logic o_cal_active;
  logic [7:0] d;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;

  // Clock of 100 ns period.
  always #50 i_ref_clk = ~i_ref_clk;

  slc_keypad_op slc_keypad_op_i (
    .i_ref_clk(i_ref_clk),
    .o_key_vld(key_vld),
    .o_key(key)
  );

  slc_lockout_ctl slc_lockout_ctl_i (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_key_vld(key_vld),
    .i_key(key),
    .i_cal_jumper(i_cal_jumper),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .o_lock_on(o_lock_on),
    .o_autocorr_on(o_autocorr_on),
    .o_msg(o_msg),
    .o_disp_code(o_disp_code),
    .o_range(o_range),
    .o_trig(o_trig),
    .o_delay(o_delay),
    .o_comm(o_comm),
    .o_line(o_line),
    .o_cal_active(o_cal_active)
  );

  // Prints the verdict and ends the run.
  task automatic print_verdict();
    if (failures == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  // Cuts a hang short.
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end

  // Compares one value and reports a mismatch.
  task automatic chk(input string n, input logic [11:0] e,
                     input logic [11:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Register write, one strobe cycle.
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr

  // Register read; data are taken in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
  endtask : rd

  // Lets the dialogue settle, then checks the message and lock state.
  task automatic see(input slc_pkg::slc_msg_t m, input logic lk);
    repeat (3) @(posedge i_ref_clk);
    #1;
    chk("msg", {8'h00, m}, {8'h00, o_msg});
    chk("lock", {11'h000, lk}, {11'h000, o_lock_on});
  endtask : see

  // Reset state, register access and the calibration gate while open.
  task automatic t_reset_regs();
    see(slc_pkg::MSG_MAIN, 1'b0);
    chk("autocorr", 12'h001, {11'h000, o_autocorr_on});
    chk("range", 12'h00B, {7'h00, o_range});
    rd(slc_pkg::OFS_STATUS, d);
    chk("st_autoc", 12'h001, {11'h000, d[2]});
    rd(4'hF, d);
    chk("unmapped", 12'h000, {4'h0, d});
    wr(slc_pkg::OFS_DELAY, 8'h20);
    rd(slc_pkg::OFS_DELAY, d);
    chk("delay", 12'h020, {4'h0, d});
    wr(slc_pkg::OFS_RANGE, 8'h13);
    wr(slc_pkg::OFS_TRIG, 8'h02);
    wr(slc_pkg::OFS_COMM, 8'h01);
    #1;
    chk("range_w", 12'h013, {7'h00, o_range});
    chk("trig_w", 12'h002, {10'h000, o_trig});
    chk("comm_w", 12'h001, {10'h000, o_comm});
    wr(slc_pkg::OFS_CAL, 8'h01);
    #1;
    chk("cal_nojmp", 12'h000, {11'h000, o_cal_active});
    rd(slc_pkg::OFS_STATUS, d);
    chk("rej_set", 12'h001, {11'h000, d[3]});
    wr(slc_pkg::OFS_STATUS, 8'h08);
    rd(slc_pkg::OFS_STATUS, d);
    chk("rej_clr", 12'h000, {11'h000, d[3]});
    @(posedge i_ref_clk);
    i_cal_jumper <= 1'b1;
    wr(slc_pkg::OFS_CAL, 8'h01);
    #1;
    chk("cal_jmp", 12'h001, {11'h000, o_cal_active});
    wr(slc_pkg::OFS_CAL, 8'h00);
  endtask : t_reset_regs

  // Lock with the factory code, then locked writes are refused.
  task automatic t_lock();
    slc_keypad_op_i.open_menu();
    see(slc_pkg::MSG_ASK_CODE, 1'b0);
    slc_keypad_op_i.type_code(12'h555);
    see(slc_pkg::MSG_TURN_ON, 1'b0);
    slc_keypad_op_i.press(slc_pkg::KEY_ENTER);
    see(slc_pkg::MSG_ACK_ON, 1'b1);
    for (int a = 0; a < 6; a++) begin
      wr(a[3:0], 8'hFF);
    end
    #1;
    chk("range", 12'h013, {7'h00, o_range});
    chk("trig", 12'h002, {10'h000, o_trig});
    chk("delay", 12'h020, {4'h0, o_delay});
    chk("comm", 12'h001, {10'h000, o_comm});
    chk("line", 12'h000, {11'h000, o_line});
    chk("cal", 12'h000, {11'h000, o_cal_active});
    rd(slc_pkg::OFS_STATUS, d);
    chk("rej", 12'h001, {11'h000, d[3]});
    chk("st_lock", 12'h001, {11'h000, d[0]});
    chk("st_jmp", 12'h001, {11'h000, d[4]});
    chk("autoc", 12'h001, {11'h000, o_autocorr_on});
  endtask : t_lock

  // Wrong code, erased digits and a refused toggle.
  task automatic t_deny_erase();
    slc_keypad_op_i.open_menu();
    slc_keypad_op_i.type_code(12'h123);
    see(slc_pkg::MSG_DENIED, 1'b1);
    slc_keypad_op_i.open_menu();
    slc_keypad_op_i.press(4'h1);
    slc_keypad_op_i.press(4'h2);
    slc_keypad_op_i.press(slc_pkg::KEY_MENU);
    slc_keypad_op_i.type_code(12'h555);
    see(slc_pkg::MSG_TURN_OFF, 1'b1);
    slc_keypad_op_i.press(slc_pkg::KEY_MENU);
    see(slc_pkg::MSG_ERROR, 1'b1);
  endtask : t_deny_erase

  // Bypass code unlocks but never locks.
  task automatic t_bypass();
    slc_keypad_op_i.open_menu();
    slc_keypad_op_i.type_code(12'h999);
    see(slc_pkg::MSG_BYPASS, 1'b1);
    slc_keypad_op_i.press(slc_pkg::KEY_ENTER);
    see(slc_pkg::MSG_ACK_OFF, 1'b0);
    slc_keypad_op_i.open_menu();
    slc_keypad_op_i.type_code(12'h999);
    see(slc_pkg::MSG_BYPASS, 1'b0);
    slc_keypad_op_i.press(slc_pkg::KEY_ENTER);
    see(slc_pkg::MSG_ACK_OFF, 1'b0);
    wr(slc_pkg::OFS_LINE, 8'h01);
    #1;
    chk("line_w", 12'h001, {11'h000, o_line});
  endtask : t_bypass

  // Change the code, check old code denied, then escape keeps it.
  task automatic t_change();
    slc_keypad_op_i.open_menu();
    slc_keypad_op_i.type_code(12'h555);
    slc_keypad_op_i.press(slc_pkg::KEY_ZERO);
    see(slc_pkg::MSG_CHG_ASK, 1'b0);
    slc_keypad_op_i.press(slc_pkg::KEY_ENTER);
    see(slc_pkg::MSG_SHOW_CODE, 1'b0);
    chk("disp", 12'h555, o_disp_code);
    slc_keypad_op_i.type_code(12'h123);
    see(slc_pkg::MSG_SAVED, 1'b0);
    slc_keypad_op_i.open_menu();
    slc_keypad_op_i.type_code(12'h555);
    see(slc_pkg::MSG_DENIED, 1'b0);
    slc_keypad_op_i.open_menu();
    slc_keypad_op_i.type_code(12'h123);
    slc_keypad_op_i.press(slc_pkg::KEY_ZERO);
    slc_keypad_op_i.press(slc_pkg::KEY_ENTER);
    slc_keypad_op_i.press(4'h7);
    slc_keypad_op_i.press(slc_pkg::KEY_MENU);
    slc_keypad_op_i.press(slc_pkg::KEY_ENTER);
    see(slc_pkg::MSG_KEPT, 1'b0);
    slc_keypad_op_i.open_menu();
    slc_keypad_op_i.type_code(12'h123);
    see(slc_pkg::MSG_TURN_ON, 1'b0);
    slc_keypad_op_i.press(slc_pkg::KEY_ENTER);
    see(slc_pkg::MSG_ACK_ON, 1'b1);
  endtask : t_change

  // Main sequence.
  initial begin
    i_rstn <= 1'b0;
    i_cal_jumper <= 1'b0;
    i_addr <= 4'h0;
    i_wdata <= 8'h00;
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    t_reset_regs();
    t_lock();
    t_deny_erase();
    t_bypass();
    t_change();
    print_verdict();
  end
endmodule : tb_slc_lockout_ctl

// file: verilog/slc_digit_acc.sv
// Three-digit BCD entry accumulator with erase on the menu/clear key.
`timescale 1ns/10ps
module slc_digit_acc (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  slc_key_if.acc kif
);

  // Digits shift in from the right; menu/clear erases all typed digits.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      kif.digits <= 12'h000;
      kif.cnt <= 2'h0;
    end else if (kif.clr || (kif.vld && kif.key == slc_pkg::KEY_MENU)) begin
      kif.digits <= 12'h000; // [R05]
      kif.cnt <= 2'h0;
    end else if (kif.vld && slc_pkg::is_digit(kif.key) &&
                 kif.cnt < slc_pkg::CODE_DIGITS) begin
      kif.digits <= {kif.digits[7:0], kif.key}; // [R05]
      kif.cnt <= kif.cnt + 2'h1;
    end
  end

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  // Menu/clear wipes the entry on the next edge.
  acc_erase_a: assert property ( // [R05]
    kif.vld && kif.key == slc_pkg::KEY_MENU |=> kif.cnt == 2'h0
  ) else $error("menu/clear did not erase digits");

  // A fourth digit never enters the buffer.
  acc_limit_a: assert property ( // [R05]
    kif.cnt == slc_pkg::CODE_DIGITS && !kif.clr &&
      !(kif.vld && kif.key == slc_pkg::KEY_MENU) |=> $stable(kif.digits)
  ) else $error("digit accepted beyond three");

endmodule : slc_digit_acc

// file: verilog/slc_key_if.sv
// Key events and digit accumulator state shared between controller parts.
`timescale 1ns/10ps
interface slc_key_if;
  logic vld;
  logic [3:0] key;
  logic clr;
  logic [11:0] digits;
  logic [1:0] cnt;

  // The dialogue drives keys and clears; the accumulator returns digits.
  modport ctl (output vld, key, clr, input digits, cnt);
  modport acc (input vld, key, clr, output digits, cnt);
endinterface : slc_key_if

// file: verilog/slc_lockout_ctl.sv
// Keypad lockout dialogue, access code store and register port.
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/10ps

// What this block does
// R01: Calibration entry only when unlocked and the calibration jumper fitted.
// R02: Temperature auto-correction always on; nothing can switch it off.
// R03: While locked, refuse range, trigger, delay, comm, line, calibration.
// R04: Menu/clear then zero opens the lockout menu and asks for code.
// R05: Three digits then enter; menu/clear erases digits typed so far.
// R06: Stored access code is 555 after reset.
// R07: Correct code offers the opposite state; enter applies and acknowledges.
// R08: Menu/clear at toggle prompt shows error, keeps state, exits.
// R09: Zero at toggle prompt asks change code; enter shows stored code.
// R10: Enter stores new digits; menu/clear then enter keeps old code.
// R11: Bypass code 999 accepted; offers only disabling, done by enter.
// R12: Bypass never enables lockout; enabling needs the stored code.
// R13: Unmatched code denies access; state and code stay unchanged.
module slc_lockout_ctl (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_key_vld,
  input wire logic [3:0] i_key,
  input wire logic i_cal_jumper,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_lock_on,
  output logic o_autocorr_on,
  output logic [3:0] o_msg,
  output logic [11:0] o_disp_code,
  output logic [4:0] o_range,
  output logic [1:0] o_trig,
  output logic [7:0] o_delay,
  output logic [1:0] o_comm,
  output logic [0:0] o_line,
  output logic o_cal_active
);

  slc_pkg::slc_state_t state_r;
  slc_pkg::slc_state_t state_nxt;
  slc_pkg::slc_msg_t msg_r;
  slc_pkg::slc_msg_t msg_nxt;
  logic lock_r;
  logic lock_nxt;
  logic [11:0] code_r;
  logic [11:0] code_nxt;
  logic [11:0] disp_nxt;
  logic [7:0] rdata_nxt;
  logic autocorr_r;
  logic rej;
  logic rej_clr;
  logic full;
  logic hit_code;
  logic hit_bypass;
  logic enter;
  logic menu;

  slc_key_if kif ();

  // Key events go straight to the accumulator.
  assign kif.vld = i_key_vld;
  assign kif.key = i_key;

  slc_digit_acc u_acc (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .kif(kif)
  );

  // Software write that clears the sticky refusal flag.
  assign rej_clr = i_wr && i_addr == slc_pkg::OFS_STATUS &&
                   i_wdata[slc_pkg::ST_REJ];

  slc_settings u_set (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_wr(i_wr),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_lock(lock_r),
    .i_jumper(i_cal_jumper),
    .i_rej_clr(rej_clr),
    .o_range(o_range),
    .o_trig(o_trig),
    .o_delay(o_delay),
    .o_comm(o_comm),
    .o_line(o_line),
    .o_cal(o_cal_active),
    .o_rej(rej)
  );

  // Decoded key and code comparisons used by the dialogue.
  assign enter = i_key_vld && i_key == slc_pkg::KEY_ENTER;
  assign menu = i_key_vld && i_key == slc_pkg::KEY_MENU;
  assign full = kif.cnt == slc_pkg::CODE_DIGITS;
  assign hit_code = full && kif.digits == code_r;
  assign hit_bypass = full && kif.digits == slc_pkg::CODE_BYPASS;

  // Dialogue next state, lockout state, stored code and message.
  always_comb begin
    state_nxt = state_r;
    msg_nxt = msg_r;
    lock_nxt = lock_r;
    code_nxt = code_r;
    kif.clr = 1'h0;
    if (i_key_vld) begin
      case (state_r)
        slc_pkg::ST_IDLE: begin
          if (menu) begin
            state_nxt = slc_pkg::ST_MENU;
            msg_nxt = slc_pkg::MSG_MENU;
          end
        end
        slc_pkg::ST_MENU: begin
          if (i_key == slc_pkg::KEY_ZERO) begin
            state_nxt = slc_pkg::ST_PIN; // [R04]
            msg_nxt = slc_pkg::MSG_ASK_CODE;
            kif.clr = 1'h1;
          end else begin
            state_nxt = slc_pkg::ST_IDLE;
            msg_nxt = slc_pkg::MSG_MAIN;
          end
        end
        slc_pkg::ST_PIN: begin
          if (enter && hit_code) begin
            state_nxt = slc_pkg::ST_TOGGLE; // [R07]
            msg_nxt = lock_r ? slc_pkg::MSG_TURN_OFF
                             : slc_pkg::MSG_TURN_ON;
          end else if (enter && hit_bypass) begin
            state_nxt = slc_pkg::ST_BYPASS; // [R11] [R12]
            msg_nxt = slc_pkg::MSG_BYPASS;
          end else if (enter) begin
            state_nxt = slc_pkg::ST_IDLE; // [R13]
            msg_nxt = slc_pkg::MSG_DENIED;
          end
        end
        slc_pkg::ST_TOGGLE: begin
          if (enter) begin
            lock_nxt = !lock_r; // [R07]
            state_nxt = slc_pkg::ST_IDLE;
            msg_nxt = lock_r ? slc_pkg::MSG_ACK_OFF
                             : slc_pkg::MSG_ACK_ON;
          end else if (menu) begin
            state_nxt = slc_pkg::ST_IDLE; // [R08]
            msg_nxt = slc_pkg::MSG_ERROR;
          end else if (i_key == slc_pkg::KEY_ZERO) begin
            state_nxt = slc_pkg::ST_CHG_ASK; // [R09]
            msg_nxt = slc_pkg::MSG_CHG_ASK;
          end
        end
        slc_pkg::ST_BYPASS: begin
          if (enter) begin
            lock_nxt = 1'h0; // [R11] [R12]
            state_nxt = slc_pkg::ST_IDLE;
            msg_nxt = slc_pkg::MSG_ACK_OFF;
          end else if (menu) begin
            state_nxt = slc_pkg::ST_IDLE;
            msg_nxt = slc_pkg::MSG_ERROR;
          end
        end
        slc_pkg::ST_CHG_ASK: begin
          if (enter) begin
            state_nxt = slc_pkg::ST_CHG_EDIT; // [R09]
            msg_nxt = slc_pkg::MSG_SHOW_CODE;
            kif.clr = 1'h1;
          end else if (menu) begin
            state_nxt = slc_pkg::ST_IDLE;
            msg_nxt = slc_pkg::MSG_ERROR;
          end
        end
        slc_pkg::ST_CHG_EDIT: begin
          if (enter && full) begin
            code_nxt = kif.digits; // [R10]
            state_nxt = slc_pkg::ST_IDLE;
            msg_nxt = slc_pkg::MSG_SAVED;
          end else if (menu) begin
            state_nxt = slc_pkg::ST_CHG_ESC; // [R10]
          end
        end
        slc_pkg::ST_CHG_ESC: begin
          if (enter) begin
            state_nxt = slc_pkg::ST_IDLE; // [R10]
            msg_nxt = slc_pkg::MSG_KEPT;
          end else if (slc_pkg::is_digit(i_key)) begin
            state_nxt = slc_pkg::ST_CHG_EDIT;
          end
        end
        default: begin
          state_nxt = slc_pkg::ST_IDLE;
          msg_nxt = slc_pkg::MSG_MAIN;
        end
      endcase
    end
  end

  // Dialogue state.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r <= slc_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Lockout on/off state, off after reset.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lock_r <= 1'h0;
    end else begin
      lock_r <= lock_nxt;
    end
  end

  // Stored access code.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      code_r <= slc_pkg::CODE_RST; // [R06]
    end else begin
      code_r <= code_nxt;
    end
  end

  // Display message.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      msg_r <= slc_pkg::MSG_MAIN;
    end else begin
      msg_r <= msg_nxt;
    end
  end

  // Code screen shows the stored code until a new digit is typed.
  always_comb begin
    disp_nxt = 12'h000;
    if ((state_r == slc_pkg::ST_CHG_EDIT ||
         state_r == slc_pkg::ST_CHG_ESC) && kif.cnt == 2'h0) begin
      disp_nxt = code_r; // [R09]
    end else if (state_r == slc_pkg::ST_PIN ||
                 state_r == slc_pkg::ST_CHG_EDIT ||
                 state_r == slc_pkg::ST_CHG_ESC) begin
      disp_nxt = kif.digits;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_disp_code <= 12'h000;
    end else begin
      o_disp_code <= disp_nxt;
    end
  end

  // Auto-correction is fixed on; no register reaches this flop.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      autocorr_r <= 1'h1; // [R02]
    end else begin
      autocorr_r <= 1'h1; // [R02]
    end
  end

  // Read mux; unmapped offsets read zero.
  always_comb begin
    rdata_nxt = 8'h00;
    if (i_addr == slc_pkg::OFS_RANGE) begin
      rdata_nxt = {3'h0, o_range};
    end else if (i_addr == slc_pkg::OFS_TRIG) begin
      rdata_nxt = {6'h00, o_trig};
    end else if (i_addr == slc_pkg::OFS_DELAY) begin
      rdata_nxt = o_delay;
    end else if (i_addr == slc_pkg::OFS_COMM) begin
      rdata_nxt = {6'h00, o_comm};
    end else if (i_addr == slc_pkg::OFS_LINE) begin
      rdata_nxt = {7'h00, o_line};
    end else if (i_addr == slc_pkg::OFS_CAL) begin
      rdata_nxt[slc_pkg::CAL_BIT] = o_cal_active;
    end else if (i_addr == slc_pkg::OFS_STATUS) begin
      rdata_nxt[slc_pkg::ST_LOCK] = lock_r;
      rdata_nxt[slc_pkg::ST_CAL] = o_cal_active;
      rdata_nxt[slc_pkg::ST_AUTOC] = autocorr_r; // [R02]
      rdata_nxt[slc_pkg::ST_REJ] = rej;
      rdata_nxt[slc_pkg::ST_JUMPER] = i_cal_jumper;
      rdata_nxt[slc_pkg::ST_STATE_LSB +: 3] = state_r;
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rdata_nxt;
    end else begin
      o_rdata <= 8'h00;
    end
  end

  assign o_lock_on = lock_r;
  assign o_autocorr_on = autocorr_r;
  assign o_msg = msg_r;

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  sequence menu_open_s;
    state_r == slc_pkg::ST_MENU && i_key_vld && i_key == slc_pkg::KEY_ZERO;
  endsequence

  sequence save_s;
    state_r == slc_pkg::ST_CHG_EDIT && enter && full;
  endsequence

  sequence escape_s;
    state_r == slc_pkg::ST_CHG_EDIT && menu ##[1:8]
      state_r == slc_pkg::ST_CHG_ESC && enter;
  endsequence

  // Auto-correction output never drops.
  autocorr_fixed_a: assert property ( // [R02]
    o_autocorr_on
  ) else $error("auto-correction switched off");

  // Menu then zero leads to the code prompt.
  menu_open_a: assert property ( // [R04]
    menu_open_s |=> state_r == slc_pkg::ST_PIN &&
      o_msg == slc_pkg::MSG_ASK_CODE
  ) else $error("lockout menu did not open");

  // Leaving reset, the stored code is the factory value.
  default_code_a: assert property ( // [R06]
    $rose(i_rstn) |-> code_r == slc_pkg::CODE_RST
  ) else $error("stored code not at factory value");

  // Enter at the toggle prompt inverts the lockout and exits.
  toggle_apply_a: assert property ( // [R07]
    state_r == slc_pkg::ST_TOGGLE && enter |=>
      o_lock_on != $past(o_lock_on) && state_r == slc_pkg::ST_IDLE
  ) else $error("toggle not applied");

  // Menu/clear at the toggle prompt keeps state and shows an error.
  toggle_abort_a: assert property ( // [R08]
    state_r == slc_pkg::ST_TOGGLE && menu |=>
      $stable(o_lock_on) && o_msg == slc_pkg::MSG_ERROR
  ) else $error("abort changed lockout");

  // The change screen shows the stored code two edges after enter.
  chg_show_a: assert property ( // [R09]
    state_r == slc_pkg::ST_CHG_ASK && enter |-> ##2 o_disp_code == code_r
  ) else $error("stored code not shown");

  // Enter on a full entry stores the typed code.
  code_save_a: assert property ( // [R10]
    save_s |=> code_r == $past(kif.digits)
  ) else $error("new code not stored");

  // Menu/clear then enter leaves the old code.
  code_keep_a: assert property ( // [R10]
    escape_s |=> $stable(code_r) && state_r == slc_pkg::ST_IDLE
  ) else $error("escape changed the code");

  // The bypass prompt only ever turns the lockout off.
  bypass_off_a: assert property ( // [R11] [R12]
    state_r == slc_pkg::ST_BYPASS |=> !o_lock_on || $past(o_lock_on)
  ) else $error("bypass enabled the lockout");

  // An unmatched code ends the dialogue with nothing changed.
  deny_a: assert property ( // [R13]
    state_r == slc_pkg::ST_PIN && enter && !hit_code && !hit_bypass |=>
      state_r == slc_pkg::ST_IDLE && $stable(o_lock_on) && $stable(code_r)
  ) else $error("unmatched code not denied");

endmodule : slc_lockout_ctl

// file: verilog/slc_pkg.sv
// Shared constants, key codes, offsets and types of the lockout controller.
package slc_pkg;

  // Key codes delivered by the keypad scanner; digits use 0 to 9.
  localparam logic [3:0] KEY_ZERO = 4'h0;
  localparam logic [3:0] KEY_MENU = 4'hA;
  localparam logic [3:0] KEY_ENTER = 4'hB;

  // Access code handling, three BCD digits.
  localparam logic [1:0] CODE_DIGITS = 2'h3;
  localparam logic [11:0] CODE_RST = 12'h555;
  localparam logic [11:0] CODE_BYPASS = 12'h999;

  // Register offsets on the software port.
  localparam logic [3:0] OFS_RANGE = 4'h0;
  localparam logic [3:0] OFS_TRIG = 4'h1;
  localparam logic [3:0] OFS_DELAY = 4'h2;
  localparam logic [3:0] OFS_COMM = 4'h3;
  localparam logic [3:0] OFS_LINE = 4'h4;
  localparam logic [3:0] OFS_CAL = 4'h5;
  localparam logic [3:0] OFS_STATUS = 4'h6;

  // Reset values of the protected settings.
  localparam logic [4:0] RANGE_RST = 5'h0B;
  localparam logic [1:0] TRIG_RST = 2'h0;
  localparam logic [7:0] DELAY_RST = 8'h6F;
  localparam logic [1:0] COMM_RST = 2'h0;
  localparam logic [0:0] LINE_RST = 1'h0;

  // Field positions in the calibration and status registers.
  localparam int unsigned CAL_BIT = 0;
  localparam int unsigned ST_LOCK = 0;
  localparam int unsigned ST_CAL = 1;
  localparam int unsigned ST_AUTOC = 2;
  localparam int unsigned ST_REJ = 3;
  localparam int unsigned ST_JUMPER = 4;
  localparam int unsigned ST_STATE_LSB = 5;

  // Dialogue states, Gray coded along the usual path.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_MENU = 3'h1,
    ST_PIN = 3'h3,
    ST_TOGGLE = 3'h2,
    ST_CHG_ASK = 3'h6,
    ST_CHG_EDIT = 3'h7,
    ST_CHG_ESC = 3'h5,
    ST_BYPASS = 3'h4
  } slc_state_t;

  // Messages shown on the display.
  typedef enum logic [3:0] {
    MSG_MAIN = 4'h0,
    MSG_MENU = 4'h1,
    MSG_ASK_CODE = 4'h2,
    MSG_TURN_ON = 4'h3,
    MSG_TURN_OFF = 4'h4,
    MSG_ACK_ON = 4'h5,
    MSG_ACK_OFF = 4'h6,
    MSG_ERROR = 4'h7,
    MSG_DENIED = 4'h8,
    MSG_CHG_ASK = 4'h9,
    MSG_SHOW_CODE = 4'hA,
    MSG_SAVED = 4'hB,
    MSG_KEPT = 4'hC,
    MSG_BYPASS = 4'hD
  } slc_msg_t;

  // True for a numeric key.
  function automatic logic is_digit(input logic [3:0] key);
    return key <= 4'h9;
  endfunction : is_digit

endpackage : slc_pkg

// file: verilog/slc_settings.sv
// Protected measurement settings and the calibration entry gate.
`timescale 1ns/10ps
module slc_settings (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_wr,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_lock,
  input wire logic i_jumper,
  input wire logic i_rej_clr,
  output logic [4:0] o_range,
  output logic [1:0] o_trig,
  output logic [7:0] o_delay,
  output logic [1:0] o_comm,
  output logic [0:0] o_line,
  output logic o_cal,
  output logic o_rej
);

  logic prot_wr;
  logic cal_req;
  logic cal_bad;

  // A write to a guarded setting, and a refused calibration request.
  assign prot_wr = i_wr && i_addr <= slc_pkg::OFS_LINE;
  assign cal_req = i_wr && i_addr == slc_pkg::OFS_CAL &&
                   i_wdata[slc_pkg::CAL_BIT];
  assign cal_bad = cal_req && (i_lock || !i_jumper);

  // Settings change only while the lockout is off.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_range <= slc_pkg::RANGE_RST;
      o_trig <= slc_pkg::TRIG_RST;
      o_delay <= slc_pkg::DELAY_RST;
      o_comm <= slc_pkg::COMM_RST;
      o_line <= slc_pkg::LINE_RST;
    end else if (prot_wr && !i_lock) begin // [R03]
      if (i_addr == slc_pkg::OFS_RANGE) begin
        o_range <= i_wdata[4:0];
      end else if (i_addr == slc_pkg::OFS_TRIG) begin
        o_trig <= i_wdata[1:0];
      end else if (i_addr == slc_pkg::OFS_DELAY) begin
        o_delay <= i_wdata;
      end else if (i_addr == slc_pkg::OFS_COMM) begin
        o_comm <= i_wdata[1:0];
      end else begin
        o_line <= i_wdata[0:0];
      end
    end
  end

  // Calibration opens only unlocked with the jumper fitted; leaving is free.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_cal <= 1'h0;
    end else if (cal_req) begin
      o_cal <= !i_lock && i_jumper; // [R01] [R03]
    end else if (i_wr && i_addr == slc_pkg::OFS_CAL) begin
      o_cal <= 1'h0;
    end
  end

  // Sticky refusal flag; a new refusal wins over a clear.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rej <= 1'h0;
    end else if ((prot_wr && i_lock) || cal_bad) begin
      o_rej <= 1'h1; // [R03]
    end else if (i_rej_clr) begin
      o_rej <= 1'h0;
    end
  end

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  // Calibration mode only starts from an allowed request.
  cal_gate_a: assert property ( // [R01]
    $rose(o_cal) |-> $past(!i_lock && i_jumper && cal_req)
  ) else $error("calibration entered while refused");

  // A locked delay write leaves the value and raises the flag.
  lock_guard_a: assert property ( // [R03]
    i_wr && i_lock && i_addr == slc_pkg::OFS_DELAY |=>
      $stable(o_delay) && o_rej
  ) else $error("locked setting write not refused");

endmodule : slc_settings
